// file: hw/sim_io_mapper.sv
// servo io function mapper: input pins to functions, functions to output pins
//
// Contract
// - each input setting picks a function, no or nc code; nc inverts sense
// - fifth and sixth inputs act as probe inputs when otherwise unassigned
// - same input function on several pins raises duplicate fault
// - active emergency stop raises halt fault and stops motor
// - fault clear input clears alarm unless alarm is locked
// - home input defaults to normally open; servo power on is unassigned at reset
// - limits default to normally closed; emergency stop is unassigned at reset
// - three output settings, defaults brake, ready, alarm
// - one output function may drive several output pins
// - exactly three independent output pins
// - limit inputs carry the separate limit handling setting
// - alarm output asserts while any drive alarm is present
// - ready output asserts once servo is powered on and ready and no alarm is present
`include "sim_defines.svh"

module sim_io_mapper
  import sim_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // isolated input pins, asynchronous
  input wire logic [5:0] input_pin_i,
  // input settings, one write strobe per pin
  input wire logic [5:0] in_cfg_we_i,
  input wire logic [7:0] in_cfg_data_i,
  // output settings, one write strobe per pin
  input wire logic [2:0] out_cfg_we_i,
  input wire logic [3:0] out_cfg_data_i,
  // limit handling setting
  input wire logic [3:0] limit_handling_setting_i,
  // drive status
  input wire sim_status_t status_i,
  input wire logic fault_event_i,
  input wire logic fault_locked_i,
  // output pins
  output logic [2:0] output_pin_o,
  // function levels
  output sim_fn_t fn_o,
  output logic [3:0] limit_action_o,
  output logic probe_1_o,
  output logic probe_2_o,
  output logic motor_stop_o,
  // faults
  output logic duplicate_assignment_fault_o,
  output logic emergency_halt_fault_o,
  output logic alarm_o,
  // settings readback
  output logic [7:0] in_cfg_o [6],
  output logic [3:0] out_cfg_o [3]
);

  function automatic logic multi(input logic [5:0] v);
    multi = |(v & 6'(v - 6'h1));
  endfunction : multi

  // ----------------------------------------
  // settings
  // ----------------------------------------
  logic [7:0] in_cfg [6];
  logic [3:0] out_cfg [3];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      in_cfg[0] <= `SIM_DEF_IN1;
      in_cfg[1] <= `SIM_DEF_IN2;
      in_cfg[2] <= `SIM_DEF_IN3;
      in_cfg[3] <= `SIM_DEF_IN4;
      in_cfg[4] <= `SIM_DEF_IN5;
      in_cfg[5] <= `SIM_DEF_IN6;
    end else begin
      for (int i = 0; i < `SIM_NUM_IN; i++) begin
        if (in_cfg_we_i[i]) begin
          in_cfg[i] <= in_cfg_data_i;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      out_cfg[0] <= `SIM_DEF_OUT1;
      out_cfg[1] <= `SIM_DEF_OUT2;
      out_cfg[2] <= `SIM_DEF_OUT3;
    end else begin
      for (int i = 0; i < `SIM_NUM_OUT; i++) begin
        if (out_cfg_we_i[i]) begin
          out_cfg[i] <= out_cfg_data_i;
        end
      end
    end
  end

  assign in_cfg_o = in_cfg;
  assign out_cfg_o = out_cfg;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // optocoupler levels are asynchronous to clk_i
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_meta <= 6'h00;
      pin_sync <= 6'h00;
    end else begin
      pin_meta <= input_pin_i;
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------
  // per-pin decode
  // ----------------------------------------
  sim_fn_t pin_fn [6];
  sim_fn_t pin_hit [6];
  logic [5:0] pin_assigned;

  for (genvar g = 0; g < `SIM_NUM_IN; g++) begin : g_dec
    sim_in_decode u_dec (
      .code_i(in_cfg[g]),
      .level_i(pin_sync[g]),
      .fn_o(pin_fn[g]),
      .hit_o(pin_hit[g]),
      .assigned_o(pin_assigned[g])
    );
  end

  // ----------------------------------------
  // merge and duplicate check
  // ----------------------------------------
  sim_fn_t any_fn;
  logic [5:0] v_pos, v_neg, v_home, v_son, v_clr, v_stop;
  logic dup;

  always_comb begin
    any_fn = '0;
    for (int i = 0; i < `SIM_NUM_IN; i++) begin
      any_fn = any_fn | pin_fn[i];
      v_pos[i] = pin_hit[i].pos_limit;
      v_neg[i] = pin_hit[i].neg_limit;
      v_home[i] = pin_hit[i].home;
      v_son[i] = pin_hit[i].servo_on;
      v_clr[i] = pin_hit[i].fault_clr;
      v_stop[i] = pin_hit[i].estop;
    end
  end

  // function on two or more pins
  assign dup = multi(v_pos) | multi(v_neg) | multi(v_home) | multi(v_son) | multi(v_clr)
             | multi(v_stop);

  // ----------------------------------------
  // alarm state
  // ----------------------------------------
  // clear acts on the rising edge so a held input cannot mask new faults
  logic clr_prev;
  logic clr_rise;
  logic alarm_latched;
  logic next_alarm_latched;
  logic alarm_any;

  assign clr_rise = any_fn.fault_clr & ~clr_prev;
  assign next_alarm_latched = fault_event_i ? 1'b1 :
                              (clr_rise & ~fault_locked_i) ? 1'b0 : alarm_latched;
  assign alarm_any = alarm_latched | status_i.drive_alarm | dup | any_fn.estop;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      clr_prev <= 1'b0;
      alarm_latched <= 1'b0;
    end else begin
      clr_prev <= any_fn.fault_clr;
      alarm_latched <= next_alarm_latched;
    end
  end

  // ----------------------------------------
  // output function select
  // ----------------------------------------
  logic [2:0] next_out;
  logic ready;

  // powered on, ready and free of alarm
  assign ready = status_i.servo_ready & any_fn.servo_on & ~alarm_any;

  always_comb begin
    for (int i = 0; i < `SIM_NUM_OUT; i++) begin
      // each pin decodes its own setting
      case (out_cfg[i])
        `SIM_OUT_BRAKE: next_out[i] = status_i.brake_release;
        `SIM_OUT_READY: next_out[i] = ready;
        `SIM_OUT_ALARM: next_out[i] = alarm_any;
        `SIM_OUT_POS_LIMIT: next_out[i] = any_fn.pos_limit;
        `SIM_OUT_NEG_LIMIT: next_out[i] = any_fn.neg_limit;
        `SIM_OUT_SERVO_ON: next_out[i] = any_fn.servo_on;
        default: next_out[i] = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      output_pin_o <= 3'h0;
      fn_o <= '0;
      limit_action_o <= 4'h0;
      probe_1_o <= 1'b0;
      probe_2_o <= 1'b0;
      motor_stop_o <= 1'b0;
      duplicate_assignment_fault_o <= 1'b0;
      emergency_halt_fault_o <= 1'b0;
      alarm_o <= 1'b0;
    end else begin
      output_pin_o <= next_out;
      fn_o <= any_fn;
      limit_action_o <= limit_handling_setting_i;
      probe_1_o <= pin_sync[`SIM_PROBE1_PIN] & ~pin_assigned[`SIM_PROBE1_PIN];
      probe_2_o <= pin_sync[`SIM_PROBE2_PIN] & ~pin_assigned[`SIM_PROBE2_PIN];
      motor_stop_o <= any_fn.estop;
      emergency_halt_fault_o <= any_fn.estop;
      duplicate_assignment_fault_o <= dup;
      alarm_o <= alarm_any;
    end
  end

endmodule : sim_io_mapper

// file: common/sim_defines.svh
// constants for the servo io function mapper
`ifndef SIM_DEFINES_SVH
`define SIM_DEFINES_SVH

// ----------------------------------------
// input function codes (normally-open form)
// ----------------------------------------
`define SIM_IN_NONE 8'h00
`define SIM_IN_POS_LIMIT 8'h01
`define SIM_IN_NEG_LIMIT 8'h02
`define SIM_IN_SERVO_ON 8'h03
`define SIM_IN_FAULT_CLR 8'h04
`define SIM_IN_HOME 8'h10
`define SIM_IN_ESTOP 8'h14
// normally-closed code = normally-open code + this offset (1/81, 2/82, 16/96)
`define SIM_IN_NC_OFFSET 8'h50

// ----------------------------------------
// output function codes
// ----------------------------------------
`define SIM_OUT_OFF 4'h0
`define SIM_OUT_BRAKE 4'h1
`define SIM_OUT_READY 4'h2
`define SIM_OUT_ALARM 4'h3
`define SIM_OUT_POS_LIMIT 4'h4
`define SIM_OUT_NEG_LIMIT 4'h5
`define SIM_OUT_SERVO_ON 4'h6

// ----------------------------------------
// setting reset values
// ----------------------------------------
`define SIM_DEF_IN1 8'h00
`define SIM_DEF_IN2 8'h51
`define SIM_DEF_IN3 8'h52
`define SIM_DEF_IN4 8'h10
`define SIM_DEF_IN5 8'h00
`define SIM_DEF_IN6 8'h00
`define SIM_DEF_OUT1 4'h1
`define SIM_DEF_OUT2 4'h2
`define SIM_DEF_OUT3 4'h3

// ----------------------------------------
// sizes
// ----------------------------------------
`define SIM_NUM_IN 6
`define SIM_NUM_OUT 3
`define SIM_PROBE1_PIN 4
`define SIM_PROBE2_PIN 5

`endif

// file: common/sim_pkg.sv
// types shared by the servo io function mapper
package sim_pkg;

  // ----------------------------------------
  // input function levels
  // ----------------------------------------
  typedef struct packed {
    logic pos_limit;
    logic neg_limit;
    logic home;
    logic servo_on;
    logic fault_clr;
    logic estop;
  } sim_fn_t;

  // ----------------------------------------
  // drive status sources for outputs
  // ----------------------------------------
  typedef struct packed {
    logic brake_release;
    logic servo_ready;
    logic drive_alarm;
  } sim_status_t;

endpackage : sim_pkg

// file: hw/sim_in_decode.sv
// per-pin decoder: function code and contact sense to function levels
`include "sim_defines.svh"

module sim_in_decode
  import sim_pkg::*;
(
  // setting and level
  input wire logic [7:0] code_i,
  input wire logic level_i,
  // decoded
  output sim_fn_t fn_o,
  output sim_fn_t hit_o,
  output logic assigned_o
);

  function automatic logic is_code(input logic [7:0] code, input logic [7:0] base);
    is_code = (code == base) || (code == 8'(base + `SIM_IN_NC_OFFSET));
  endfunction : is_code

  logic nc;
  logic eff;

  // ----------------------------------------
  // polarity
  // ----------------------------------------
  // nc variant inverts sense
  assign nc = (code_i >= `SIM_IN_NC_OFFSET);
  assign eff = level_i ^ nc;

  // ----------------------------------------
  // function select
  // ----------------------------------------
  // code to function
  assign hit_o.pos_limit = is_code(code_i, `SIM_IN_POS_LIMIT);
  assign hit_o.neg_limit = is_code(code_i, `SIM_IN_NEG_LIMIT);
  assign hit_o.home = is_code(code_i, `SIM_IN_HOME);
  // servo on plain code is no
  assign hit_o.servo_on = is_code(code_i, `SIM_IN_SERVO_ON);
  assign hit_o.fault_clr = is_code(code_i, `SIM_IN_FAULT_CLR);
  assign hit_o.estop = is_code(code_i, `SIM_IN_ESTOP);
  assign fn_o = eff ? hit_o : '0;
  assign assigned_o = |hit_o;

endmodule : sim_in_decode

// file: verif/sim_io_mapper_props.sv
// concurrent checks on the servo io function mapper ports
`include "sim_defines.svh"

module sim_io_mapper_props
  import sim_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // controls
  input wire logic [5:0] in_cfg_we_i,
  input wire logic [7:0] in_cfg_data_i,
  input wire logic [3:0] limit_handling_setting_i,
  input wire logic fault_event_i,
  // observed outputs
  input wire logic [2:0] output_pin_o,
  input wire sim_fn_t fn_o,
  input wire logic [3:0] limit_action_o,
  input wire logic motor_stop_o,
  input wire logic probe_1_o,
  input wire logic duplicate_assignment_fault_o,
  input wire logic emergency_halt_fault_o,
  input wire logic alarm_o,
  input wire logic [7:0] in_cfg_o [6],
  input wire logic [3:0] out_cfg_o [3]
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  chk_halt_estop: assert property (
    emergency_halt_fault_o == fn_o.estop && motor_stop_o == fn_o.estop)
    else $error("halt or stop differs from estop");
  chk_limit_copy: assert property (
    !$past(srst_i) |-> limit_action_o == $past(limit_handling_setting_i))
    else $error("limit action not copied");
  chk_cfg_write: assert property (
    in_cfg_we_i[0] |=> in_cfg_o[0] == $past(in_cfg_data_i))
    else $error("input setting not written");
  // reset itself is the cause here, so this one is not disabled by it
  chk_reset_dflt: assert property (disable iff (1'b0) srst_i |=>
    in_cfg_o[3] == `SIM_DEF_IN4 && in_cfg_o[1] == `SIM_DEF_IN2 && out_cfg_o[2] == `SIM_DEF_OUT3)
    else $error("settings not at defaults after reset");
  chk_alarm_pin: assert property (
    out_cfg_o[2] == `SIM_OUT_ALARM && $stable(out_cfg_o[2]) |-> output_pin_o[2] == alarm_o)
    else $error("alarm pin differs from alarm");
  chk_dup_alarm: assert property (
    duplicate_assignment_fault_o |-> alarm_o)
    else $error("duplicate fault without alarm");
  chk_fault_set: assert property (
    fault_event_i |-> ##[1:2] alarm_o)
    else $error("fault event not latched");
  chk_multi_pin: assert property (
    out_cfg_o[0] == out_cfg_o[1] && $stable(out_cfg_o[0]) && $stable(out_cfg_o[1])
    |-> output_pin_o[0] == output_pin_o[1])
    else $error("shared function drives pins apart");
  chk_probe_owned: assert property (
    in_cfg_o[4] == `SIM_IN_ESTOP && $stable(in_cfg_o[4]) |-> !probe_1_o)
    else $error("probe active on an assigned pin");
endmodule : sim_io_mapper_props

// file: verif/sim_field_model.sv
// field side model: switch contacts feeding the isolated input pins
module sim_field_model (
  // commanded contact states, high = conducting
  input wire logic [5:0] contact_i,
  // pins toward the drive
  output wire logic [5:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // contacts settle off the clock edge, as real switches are unrelated to it
  // a continuous path avoids missing the time-zero contact value
  assign #3 pin_o = contact_i;
endmodule : sim_field_model

// file: verif/sim_io_mapper_tb.sv
// self-checking bench for the servo io function mapper
`include "sim_defines.svh"

module sim_io_mapper_tb
  import sim_pkg::*;
  ();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, srst_i, fault_event_i, fault_locked_i, smp, latch, clr_prev;
  logic pr1, pr2, mstop, dup, halt, alarm;
  logic [5:0] contact, pin_w, pins, in_we, c;
  logic [7:0] in_data;
  logic [7:0] in_cfg [6];
  logic [7:0] codes [6] = '{`SIM_DEF_IN1, `SIM_DEF_IN2, `SIM_DEF_IN3, `SIM_DEF_IN4,
                            `SIM_DEF_IN5, `SIM_DEF_IN6};
  logic [2:0] out_we, opin;
  logic [3:0] out_data, lim, lact;
  logic [3:0] out_cfg [3];
  logic [3:0] ocfg [3] = '{`SIM_DEF_OUT1, `SIM_DEF_OUT2, `SIM_DEF_OUT3};
  logic [7:0] tab [11] = '{8'h00, 8'h03, 8'h53, 8'h04, 8'h54, 8'h14, 8'h64, 8'h01, 8'h51,
                           8'h10, 8'h05};
  sim_status_t status;
  sim_fn_t fn;
  logic [18:0] expq [$];
  int num_errors, n_compared, cyc;

  sim_field_model i_field (.contact_i(contact), .pin_o(pin_w));
  sim_io_mapper i_dut (.clk_i, .srst_i, .input_pin_i(pin_w), .in_cfg_we_i(in_we),
    .in_cfg_data_i(in_data), .out_cfg_we_i(out_we), .out_cfg_data_i(out_data),
    .limit_handling_setting_i(lim), .status_i(status), .fault_event_i, .fault_locked_i,
    .output_pin_o(opin), .fn_o(fn), .limit_action_o(lact), .probe_1_o(pr1), .probe_2_o(pr2),
    .motor_stop_o(mstop), .duplicate_assignment_fault_o(dup), .emergency_halt_fault_o(halt),
    .alarm_o(alarm), .in_cfg_o(in_cfg), .out_cfg_o(out_cfg));

  function automatic logic [18:0] exp_obs();
    logic [5:0] v, asg;
    logic [7:0] b;
    logic [6:0] src;
    logic [2:0] o;
    logic d, a;
    int j;
    int n [6];
    v = '0;
    d = 1'b0;
    n = '{default: 0};
    for (int i = 0; i < 6; i++) begin
      b = codes[i] >= `SIM_IN_NC_OFFSET ? codes[i] - `SIM_IN_NC_OFFSET : codes[i];
      j = b == `SIM_IN_POS_LIMIT ? 5 : b == `SIM_IN_NEG_LIMIT ? 4 : b == `SIM_IN_HOME ? 3 :
          b == `SIM_IN_SERVO_ON ? 2 : b == `SIM_IN_FAULT_CLR ? 1 : b == `SIM_IN_ESTOP ? 0 : -1;
      asg[i] = j >= 0;
      if (j >= 0) begin
        v[j] = v[j] | (pins[i] ^ (codes[i] >= `SIM_IN_NC_OFFSET));
        n[j]++;
        d = d | (n[j] > 1);
      end
    end
    a = latch | status.drive_alarm | d | v[0];
    src = {v[2], v[4], v[5], a, status.servo_ready & v[2] & ~a, status.brake_release, 1'b0};
    for (int k = 0; k < 3; k++) o[k] = ocfg[k] <= 4'h6 ? src[ocfg[k][2:0]] : 1'b0;
    return {v, o, d, v[0], v[0], a, pins[4] & ~asg[4], pins[5] & ~asg[5], lim};
  endfunction : exp_obs

  task automatic cmp_obs(input logic [18:0] e, input logic [18:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH outputs exp %h got %h", e, g);
    end
  endtask : cmp_obs

  task automatic cmp_cfg(input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH setting exp %h got %h", e, g);
    end
  endtask : cmp_cfg

  // a clear edge is judged between two samples, so the latch mirror follows it here
  task automatic apply(input logic [5:0] p, input sim_status_t s);
    logic [18:0] e;
    contact <= p;
    status <= s;
    pins = p;
    repeat (6) @(posedge clk_i);
    e = exp_obs();
    if (e[14] && !clr_prev && !fault_locked_i) begin
      latch = 1'b0;
      e = exp_obs();
    end
    clr_prev = e[14];
    expq.push_back(e);
    smp <= 1'b1;
    @(posedge clk_i);
    smp <= 1'b0;
  endtask : apply

  task automatic wr_in(input int i, input logic [7:0] d);
    in_we <= 6'h01 << i;
    in_data <= d;
    codes[i] = d;
    @(posedge clk_i);
    in_we <= '0;
    @(posedge clk_i);
    cmp_cfg(d, in_cfg[i]);
  endtask : wr_in

  task automatic wr_out(input logic [2:0] m, input logic [3:0] d);
    out_we <= m;
    out_data <= d;
    for (int k = 0; k < 3; k++) if (m[k]) ocfg[k] = d;
    @(posedge clk_i);
    out_we <= '0;
    @(posedge clk_i);
  endtask : wr_out

  task automatic test_done();
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      test_done();
    end
    if (smp) cmp_obs(expq.pop_front(), {fn, opin, dup, halt, mstop, alarm, pr1, pr2, lact});
  end

  initial begin
    {srst_i, fault_event_i, fault_locked_i, smp, latch, clr_prev} = 6'h20;
    {contact, in_we, in_data, out_we, out_data, status} = '0;
    void'($urandom(32'ha01e));
    lim = 4'($urandom);
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 6; i++) cmp_cfg(codes[i], in_cfg[i]);
    for (int k = 0; k < 3; k++) cmp_cfg({4'h0, ocfg[k]}, {4'h0, out_cfg[k]});
    apply(6'h06, 3'b000);
    apply(6'h39, 3'b110);
    // duplicates are forced to agree, since how clashing levels merge is not defined
    for (int t = 0; t < 11; t++) begin
      wr_in(0, tab[t]);
      repeat (2) begin
        c = 6'($urandom);
        case (tab[t])
          8'h01: c[0] = ~c[1];
          8'h51: c[0] = c[1];
          8'h10: c[0] = c[3];
          default: ;
        endcase
        apply(c, 3'($urandom));
      end
    end
    wr_in(4, `SIM_IN_ESTOP);
    apply(6'h10, 3'b000);
    wr_in(4, `SIM_IN_NONE);
    wr_in(0, `SIM_IN_SERVO_ON);
    for (int k = 0; k < 7; k++) begin
      wr_out(3'b111, 4'(k));
      repeat (2) apply(6'($urandom), 3'($urandom));
    end
    wr_out(3'b001, `SIM_OUT_BRAKE);
    wr_out(3'b010, `SIM_OUT_READY);
    wr_out(3'b100, `SIM_OUT_ALARM);
    apply(6'h07, 3'b110);
    apply(6'h07, 3'b011);
    wr_in(0, `SIM_IN_FAULT_CLR);
    fault_locked_i <= 1'b1;
    apply(6'h06, 3'b000);
    fault_event_i <= 1'b1;
    @(posedge clk_i);
    fault_event_i <= 1'b0;
    latch = 1'b1;
    apply(6'h07, 3'b000);
    apply(6'h06, 3'b000);
    fault_locked_i <= 1'b0;
    apply(6'h07, 3'b000);
    // mid-run reset must bring every changed setting back to its default
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    codes = '{`SIM_DEF_IN1, `SIM_DEF_IN2, `SIM_DEF_IN3, `SIM_DEF_IN4, `SIM_DEF_IN5,
              `SIM_DEF_IN6};
    ocfg = '{`SIM_DEF_OUT1, `SIM_DEF_OUT2, `SIM_DEF_OUT3};
    {latch, clr_prev} = 2'b00;
    @(posedge clk_i);
    for (int i = 0; i < 6; i++) cmp_cfg(codes[i], in_cfg[i]);
    for (int k = 0; k < 3; k++) cmp_cfg({4'h0, ocfg[k]}, {4'h0, out_cfg[k]});
    apply(6'h06, 3'b000);
    test_done();
  end
endmodule : sim_io_mapper_tb

bind sim_io_mapper sim_io_mapper_props i_props (.clk_i, .srst_i, .in_cfg_we_i, .in_cfg_data_i,
  .limit_handling_setting_i, .fault_event_i, .output_pin_o, .fn_o, .limit_action_o,
  .motor_stop_o, .probe_1_o, .duplicate_assignment_fault_o, .emergency_halt_fault_o, .alarm_o,
  .in_cfg_o, .out_cfg_o);
